// ---- core/curi_consts.svh ----
/*
  Constants of the cache-upgrade request issue block: command word fields,
  address/data fields and counts.
  Assumes inclusion by the package, design, bench and checker files of this block.
*/
// What this block does
// - Store or exclusive prefetch hitting a shared block raises an upgrade request.
// - Each upgrade is one address cycle, no data cycle, valid strobe asserted.
// - Command bit 11 low; a free request number on bits 10:8.
// - Upgrade command code on command bits 7:5.
// - Upgrade cause code on command bits 4:3.
// - Prior block state on bits 2:1; command bit 0 driven high.
// - Target indication on address/data bits 63:60.
// - Cache way on address/data bit 57.
// - Physical block address on address/data bits 39:0.
// - Issue only while holding bus mastership.
// - Issue only if read-ready was asserted two cycles earlier.
// - Hold back when the outstanding-request limit would be exceeded.
// - Issue only when a request number is free.
// - Withhold while a conflicting external coherency request is outstanding.
// - At most four upgrade requests outstanding at once.
// - From slave state, request mastership; wait for grant and release.
`ifndef CURI_CONSTS_SVH
`define CURI_CONSTS_SVH

`define CURI_CMD_W          12
`define CURI_AD_W           64
`define CURI_PADDR_W        40
`define CURI_REQNUM_W       3
`define CURI_NUM_REQNUMS    8
`define CURI_MAX_UPGRADES   4
`define CURI_RDY_DELAY      2

`define CURI_CMD_DATA_BIT   11
`define CURI_CMD_REQNUM_HI  10
`define CURI_CMD_REQNUM_LO  8
`define CURI_CMD_CODE_HI    7
`define CURI_CMD_CODE_LO    5
`define CURI_CMD_CAUSE_HI   4
`define CURI_CMD_CAUSE_LO   3
`define CURI_CMD_STATE_HI   2
`define CURI_CMD_STATE_LO   1
`define CURI_CMD_ONE_BIT    0

`define CURI_AD_TARGET_HI   63
`define CURI_AD_TARGET_LO   60
`define CURI_AD_WAY_BIT     57
`define CURI_AD_ADDR_HI     39

`define CURI_UPGRADE_CODE   3'h2
`define CURI_UPGRADE_CAUSE  2'h0

`endif

// ---- core/curi_pkg.sv ----
/*
  Types of the cache-upgrade request issue block.
  Assumes the constants header sits beside it.
*/
`include "curi_consts.svh"

package curi_pkg;

  typedef struct packed {
    logic [`CURI_PADDR_W-1:0] paddr;
    logic [1:0]               former_state;
    logic                     way;
    logic [3:0]               target;
    logic                     exclusive_op;
  } curi_upg_req_s;

  typedef struct packed {
    logic [`CURI_CMD_W-1:0] cmd;
    logic [`CURI_AD_W-1:0]  addr_data;
    logic                   valid_n;
    logic                   request_n;
  } curi_bus_out_s;

  typedef struct packed {
    logic grant_n;
    logic release_n;
    logic read_ready_n;
  } curi_bus_in_s;

  typedef struct packed {
    logic                     done;
    logic [`CURI_REQNUM_W-1:0] reqnum;
  } curi_resp_s;

  typedef enum logic [1:0] {
    CURI_SLAVE,
    CURI_WAIT_GRANT,
    CURI_MASTER
  } curi_mst_e;

endpackage : curi_pkg

// ---- core/curi_reqnum_pool.sv ----
/*
  Request number pool: tracks numbers in use and upgrades outstanding,
  offers the lowest free number.
  Assumes allocate is only asserted while free_avail is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "curi_consts.svh"

module curi_reqnum_pool
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  // Allocation
  input  wire logic                       alloc,
  input  wire logic                       resp_done,
  input  wire logic [`CURI_REQNUM_W-1:0]  resp_num,
  // State
  output logic                            free_avail,
  output logic [`CURI_REQNUM_W-1:0]       free_num,
  output logic [2:0]                      outstanding
);
  import curi_pkg::*;

  typedef struct packed {
    logic [`CURI_NUM_REQNUMS-1:0] busy;
    logic [2:0]                   count;
  } curi_pool_s;

  curi_pool_s st;
  curi_pool_s next_st;
  logic       rel;

  always_comb
  begin
    free_avail = 1'b0;
    free_num   = 3'h0;
    for (int i = `CURI_NUM_REQNUMS - 1; i >= 0; i--)
    begin
      if (!st.busy[i])
      begin
        free_avail = 1'b1;
        free_num   = 3'(i);
      end
    end
  end

  assign outstanding = st.count;
  assign rel         = resp_done && st.busy[resp_num];

  always_comb
  begin
    next_st = st;
    // A number stays busy from issue to its completing response
    if (rel)
      next_st.busy[resp_num] = 1'b0;
    if (alloc)
      next_st.busy[free_num] = 1'b1;
    if (alloc && !rel)
      next_st.count = st.count + 3'h1;
    else if (rel && !alloc)
      next_st.count = st.count - 3'h1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule // curi_reqnum_pool

`default_nettype wire

// ---- core/curi_upgrade_issue.sv ----
/*
  Upgrade request issue: takes upgrade requests from the secondary-cache
  side, wins bus mastership and drives one address cycle per request.
  Assumes bus inputs are asynchronous pins and the response inputs come
  from logic on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "curi_consts.svh"

module curi_upgrade_issue
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // Cache side request
  input  wire logic                        upg_valid,
  input  wire curi_pkg::curi_upg_req_s     upg_req,
  input  wire logic                        upg_shared_hit,
  output logic                             upg_ready,
  // Mode and coherency status
  input  wire logic [1:0]                  outstanding_request_limit,
  input  wire logic                        coherency_conflict,
  // Completed responses
  input  wire curi_pkg::curi_resp_s        resp,
  // System bus pins
  input  wire logic                        mastership_grant_n,
  input  wire logic                        mastership_release_n,
  input  wire logic                        read_flow_ready_n,
  output logic                             mastership_request_n,
  output logic                             bus_valid_n,
  output logic [`CURI_CMD_W-1:0]           bus_command_word,
  output logic [`CURI_AD_W-1:0]            bus_addr_data,
  output logic [`CURI_REQNUM_W-1:0]        issued_reqnum
);
  import curi_pkg::*;

  typedef struct packed {
    curi_bus_in_s  sync1;
    curi_bus_in_s  sync2;
    curi_mst_e     mst;
    curi_bus_out_s bus;
    logic [`CURI_REQNUM_W-1:0] num;
  } curi_issue_s;

  curi_issue_s st;
  curi_issue_s next_st;

  logic                      free_avail;
  logic [`CURI_REQNUM_W-1:0] free_num;
  logic [2:0]                outstanding;
  logic                      want;
  logic                      can_issue;
  logic [2:0]                limit;

  // Limit mode encodes 1 to 4 outstanding requests
  function automatic logic [2:0] curi_limit(input logic [1:0] mode);
    return {1'b0, mode} + 3'h1;
  endfunction

  // Build the address-cycle command word
  function automatic logic [`CURI_CMD_W-1:0] curi_cmd(
    input logic [`CURI_REQNUM_W-1:0] n,
    input logic [1:0]                state);
    logic [`CURI_CMD_W-1:0] c;
    c = '0;
    c[`CURI_CMD_DATA_BIT] = 1'b0;
    c[`CURI_CMD_REQNUM_HI:`CURI_CMD_REQNUM_LO] = n;
    c[`CURI_CMD_CODE_HI:`CURI_CMD_CODE_LO] = `CURI_UPGRADE_CODE;
    c[`CURI_CMD_CAUSE_HI:`CURI_CMD_CAUSE_LO] = `CURI_UPGRADE_CAUSE;
    c[`CURI_CMD_STATE_HI:`CURI_CMD_STATE_LO] = state;
    c[`CURI_CMD_ONE_BIT] = 1'b1;
    return c;
  endfunction

  // Build the address-cycle address/data word
  function automatic logic [`CURI_AD_W-1:0] curi_ad(input curi_upg_req_s r);
    logic [`CURI_AD_W-1:0] a;
    a = '0;
    a[`CURI_AD_TARGET_HI:`CURI_AD_TARGET_LO] = r.target;
    a[`CURI_AD_WAY_BIT] = r.way;
    a[`CURI_AD_ADDR_HI:0] = r.paddr;
    return a;
  endfunction

  curi_reqnum_pool u_pool
  (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .alloc       (can_issue),
    .resp_done   (resp.done),
    .resp_num    (resp.reqnum),
    .free_avail  (free_avail),
    .free_num    (free_num),
    .outstanding (outstanding)
  );

  assign limit = curi_limit(outstanding_request_limit);

  // Only stores or exclusive prefetches that hit a shared block
  assign want = upg_valid && upg_shared_hit && upg_req.exclusive_op;

  assign can_issue = want
                  && (st.mst == CURI_MASTER)
                  && !st.sync2.read_ready_n
                  && (outstanding < limit)
                  && (outstanding < 3'(`CURI_MAX_UPGRADES))
                  && free_avail
                  && !coherency_conflict;

  assign upg_ready = can_issue;

  always_comb
  begin
    next_st = st;
    next_st.sync1.grant_n      = mastership_grant_n;
    next_st.sync1.release_n    = mastership_release_n;
    next_st.sync1.read_ready_n = read_flow_ready_n;
    // Second flop holds ready as it stood two edges before the address cycle
    next_st.sync2 = st.sync1;

    unique case (st.mst)
      CURI_SLAVE:
      begin
        if (want)
        begin
          next_st.bus.request_n = 1'b0;
          next_st.mst = CURI_WAIT_GRANT;
        end
      end
      CURI_WAIT_GRANT:
      begin
        if (!st.sync2.grant_n && !st.sync2.release_n)
          next_st.mst = CURI_MASTER;
      end
      CURI_MASTER:
      begin
        if (st.sync2.grant_n)
        begin
          next_st.mst = CURI_SLAVE;
          next_st.bus.request_n = 1'b1;
        end
      end
      default:
        next_st.mst = CURI_SLAVE;
    endcase

    // One address cycle, no data cycle
    next_st.bus.valid_n = !can_issue;
    if (can_issue)
    begin
      next_st.bus.cmd       = curi_cmd(free_num, upg_req.former_state);
      next_st.bus.addr_data = curi_ad(upg_req);
      next_st.num           = free_num;
      if (!want || outstanding + 3'h1 >= limit)
        next_st.bus.request_n = 1'b1;
    end
    else if (st.mst == CURI_MASTER && want)
      next_st.bus.request_n = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st                 <= '0;
      st.sync1           <= '1;
      st.sync2           <= '1;
      st.mst             <= CURI_SLAVE;
      st.bus.valid_n     <= 1'b1;
      st.bus.request_n   <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign mastership_request_n = st.bus.request_n;
  assign bus_valid_n          = st.bus.valid_n;
  assign bus_command_word     = st.bus.cmd;
  assign bus_addr_data        = st.bus.addr_data;
  assign issued_reqnum        = st.num;

endmodule // curi_upgrade_issue

`default_nettype wire

// ---- tb/cache_upgrade_request_issue_bench.sv ----
/* Self-checking bench of the upgrade issue block.
   Assumes the agent model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "curi_consts.svh"
module cache_upgrade_request_issue_bench;
  import curi_pkg::*;
  logic clk_sys = 0, rstn = 0, upg_valid = 0, upg_shared_hit = 0, coherency_conflict = 0, throttle = 0, slow = 0;
  logic upg_ready, grant_n, rel_n, rdy_n, req_n, valid_n, c, t;
  logic [1:0] limit = 2'h3;
  logic [11:0] cmd;
  logic [63:0] ad;
  logic [2:0] inum;
  logic [7:0] busy;
  logic [75:0] exp_q[$];
  logic [75:0] exp_w;
  curi_upg_req_s upg_req = '0;
  curi_resp_s resp;
  int n_errors = 0, checks_done = 0, num, i, k;
  curi_upgrade_issue curi_upgrade_issue_i (.clk_sys, .rstn, .upg_valid, .upg_req, .upg_shared_hit, .upg_ready,
    .outstanding_request_limit(limit), .coherency_conflict, .resp, .mastership_grant_n(grant_n),
    .mastership_release_n(rel_n), .read_flow_ready_n(rdy_n), .mastership_request_n(req_n),
    .bus_valid_n(valid_n), .bus_command_word(cmd), .bus_addr_data(ad), .issued_reqnum(inum));
  curi_agent_model curi_agent_model_i (.clk_sys, .rstn, .throttle, .slow, .mastership_request_n(req_n),
    .bus_valid_n(valid_n), .bus_command_word(cmd), .mastership_grant_n(grant_n),
    .mastership_release_n(rel_n), .read_flow_ready_n(rdy_n), .resp);
  always #4 clk_sys = ~clk_sys;
  task automatic check(input logic [75:0] got, input logic [75:0] want);
    checks_done++;
    if (got !== want)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, want);
    end
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reference model: lowest free number, expected cycle per take
  always @(posedge clk_sys)
    if (!rstn)
      busy = 8'h00;
    else
    begin
      if (valid_n === 1'b0)
      begin
        if (exp_q.size() == 0)
          check(76'h1, 76'h0);
        else
        begin
          exp_w = exp_q.pop_front();
          check({cmd, ad}, exp_w);
          check(76'(inum), 76'(exp_w[74:72]));
        end
      end
      if (upg_valid && upg_ready === 1'b1)
      begin
        num = 0;
        while (busy[num] && num < 7)
          num++;
        exp_q.push_back({1'b0, 3'(num), `CURI_UPGRADE_CODE, `CURI_UPGRADE_CAUSE, upg_req.former_state, 1'b1,
                         upg_req.target, 2'h0, upg_req.way, 17'h0, upg_req.paddr});
        busy[num] = 1'b1;
      end
      if (resp.done)
        busy[resp.reqnum] = 1'b0;
    end
  task automatic send(input bit ok);
    c = 1'($urandom);
    t = throttle;
    upg_req <= {40'($urandom), 2'($urandom), 1'($urandom), 4'($urandom), ok | c};
    upg_shared_hit <= ok | ~c;
    coherency_conflict <= c;
    upg_valid <= 1'b1;
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk_sys);
      if (upg_ready === 1'b1 || (k == 8 && !ok))
        break;
      if (k == 4)
        coherency_conflict <= 1'b0;
      if (k == 12)
        throttle <= 1'b0;
    end
    check(76'(upg_ready === 1'b1), 76'(ok));
    check(76'(ok && (c && k < 5 || t && k < 12)), 76'h0);
    if (!ok)
    begin
      upg_valid <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic drain(input int tn);
    upg_valid <= 1'b0;
    repeat (60) @(posedge clk_sys);
    check(76'(exp_q.size()), 76'h0);
    $display("test %0d done", tn);
  endtask
  initial
  begin
    void'($urandom(8700));
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 40; i++)
      send(1'($urandom));
    drain(1);
    slow <= 1'b1;
    for (i = 0; i < 24; i++)
    begin
      limit <= 2'(i / 6);
      send(1'b1);
    end
    drain(2);
    slow <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      throttle <= 1'b1;
      repeat (6) @(posedge clk_sys);
      send(1'b1);
    end
    drain(3);
    send(1'b1);
    upg_valid <= 1'b0;
    rstn <= 1'b0;
    @(posedge clk_sys);
    check(76'({valid_n, req_n}), 76'h3);
    exp_q.delete();
    rstn <= 1'b1;
    for (i = 0; i < 10; i++)
      send(1'b1);
    drain(4);
    print_verdict;
  end
  initial
  begin
    #400000;
    n_errors++;
    print_verdict;
  end
endmodule // cache_upgrade_request_issue_bench
`default_nettype wire

// ---- tb/curi_agent_model.sv ----
/* System agent model: grants mastership, throttles, answers requests.
   Assumes one clock shared with the issue block. */
`timescale 1ns/1ns
`default_nettype none
module curi_agent_model
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Bench control
  input  wire logic        throttle,
  input  wire logic        slow,
  // Bus pins
  input  wire logic        mastership_request_n,
  input  wire logic        bus_valid_n,
  input  wire logic [11:0] bus_command_word,
  output logic             mastership_grant_n,
  output logic             mastership_release_n,
  output logic             read_flow_ready_n,
  output curi_pkg::curi_resp_s resp
);
  logic [2:0] pend[$];
  int         wait_n;
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      mastership_grant_n <= 1'b1;
      mastership_release_n <= 1'b1;
      read_flow_ready_n <= 1'b1;
      resp <= '0;
      wait_n = 0;
      pend.delete();
    end
    else
    begin
      mastership_grant_n <= mastership_request_n;
      mastership_release_n <= mastership_request_n;
      read_flow_ready_n <= throttle;
      if (!bus_valid_n)
        pend.push_back(bus_command_word[10:8]);
      resp.done <= 1'b0;
      if (pend.size() > 0 && wait_n >= (slow ? 24 : 2))
      begin
        resp.done <= 1'b1;
        resp.reqnum <= pend.pop_front();
        wait_n = 0;
      end
      else
        wait_n++;
    end
endmodule // curi_agent_model
`default_nettype wire

// ---- tb/curi_upgrade_issue_asserts.sv ----
/* Port checker of the upgrade issue block.
   Assumes it is bound to curi_upgrade_issue. */
`timescale 1ns/1ns
`default_nettype none
`include "curi_consts.svh"
module curi_upgrade_issue_asserts
(
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  // Cache side and status
  input wire logic                    upg_valid,
  input wire curi_pkg::curi_upg_req_s upg_req,
  input wire logic                    upg_shared_hit,
  input wire logic                    upg_ready,
  input wire logic [1:0]              outstanding_request_limit,
  input wire logic                    coherency_conflict,
  input wire curi_pkg::curi_resp_s    resp,
  // Bus pins
  input wire logic                    mastership_grant_n,
  input wire logic                    read_flow_ready_n,
  input wire logic                    bus_valid_n,
  input wire logic [11:0]             bus_command_word,
  input wire logic [63:0]             bus_addr_data,
  input wire logic [2:0]              issued_reqnum
);
  logic [2:0] cnt;
  logic [7:0] busy;
  wire logic  take;
  assign take = upg_valid && upg_ready;
  // Outstanding count and numbers in use, as seen at the ports
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      cnt  <= 3'h0;
      busy <= 8'h00;
    end
    else
    begin
      cnt  <= cnt + 3'(take) - 3'(resp.done);
      busy <= (busy | (bus_valid_n ? 8'h00 : 8'h01 << bus_command_word[10:8]))
              & ~(resp.done ? 8'h01 << resp.reqnum : 8'h00);
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_cmd_fixed_fields: assert property (
    !bus_valid_n |-> !bus_command_word[11] && bus_command_word[0] && bus_command_word[7:5] == `CURI_UPGRADE_CODE
    && bus_command_word[4:3] == `CURI_UPGRADE_CAUSE) else $error("fixed command fields wrong");
  a_take_issues: assert property (
    take |=> !bus_valid_n && bus_addr_data[39:0] == $past(upg_req.paddr) && bus_addr_data[57] == $past(upg_req.way)
    && bus_addr_data[63:60] == $past(upg_req.target) && bus_command_word[2:1] == $past(upg_req.former_state))
    else $error("taken request not issued as sent");
  a_issue_has_cause: assert property (!bus_valid_n |-> $past(take)) else $error("cycle without request");
  a_ready_eligible: assert property (
    upg_ready |-> upg_shared_hit && upg_req.exclusive_op && !coherency_conflict) else $error("ready when ineligible");
  a_ready_master: assert property (upg_ready |-> $past(!mastership_grant_n, 3)) else $error("ready without grant");
  a_ready_flow: assert property (upg_ready |-> $past(!read_flow_ready_n, 2)) else $error("ready while throttled");
  a_limit_kept: assert property (
    upg_ready |-> cnt <= {1'b0, outstanding_request_limit} && cnt < 3'h4) else $error("limit exceeded");
  a_number_free: assert property (
    !bus_valid_n |-> !busy[bus_command_word[10:8]] && issued_reqnum == bus_command_word[10:8])
    else $error("request number in use");
endmodule // curi_upgrade_issue_asserts
bind curi_upgrade_issue curi_upgrade_issue_asserts curi_upgrade_issue_asserts_i (.clk_sys, .rstn, .upg_valid,
  .upg_req, .upg_shared_hit, .upg_ready, .outstanding_request_limit, .coherency_conflict, .resp,
  .mastership_grant_n, .read_flow_ready_n, .bus_valid_n, .bus_command_word, .bus_addr_data, .issued_reqnum);
`default_nettype wire
